//--- verification/ptpise_pin_src.sv
/* ptpise_pin_src: source model driving the two capture pins.
   Assumes go pulses arrive at least eight cycles apart. */
`timescale 1ns/1ps
`default_nettype none
module ptpise_pin_src (
   // clock
   input  wire logic       clk_sys,
   // command and pins, bit 1 is pin 9
   input  wire logic [1:0] go,
   output logic      [1:0] pin
);
   int unsigned hold [2];
   // pulse stays high six cycles, well over the least active time
   always @(posedge clk_sys) begin
      for (int i = 0; i < 2; i++) begin
         if (go[i]) hold[i] <= 6;
         else if (hold[i] != 0) hold[i] <= hold[i] - 1;
      end
   end
   assign pin = {hold[1] != 0, hold[0] != 0};
endmodule
`default_nettype wire

//--- verification/ptpise_top_sva.sv
/* ptpise_top_sva: port assertions for ptpise_top.
   Assumes clk_en held high and pin 8 configured for rising edges. */
`timescale 1ns/1ps
`default_nettype none
module ptpise_top_sva (
   // clock, reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // watched ports
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_rdata,
   input  wire logic        pin8_in,
   input  wire logic        pin8_capture_cfg,
   input  wire logic        pin8_falling_edge,
   input  wire logic        pin8_lock_en,
   input  wire logic        pin8_capture_strobe,
   input  wire logic [1:0]  pin8_event_mode,
   input  wire logic        pin8_flag_out,
   input  wire logic [63:0] clock_value,
   input  wire logic [31:0] target_upper_word,
   input  wire logic [31:0] target_lower_word,
   input  wire logic        time_protocol_summary_enable,
   input  wire logic        time_protocol_summary_flag,
   input  wire logic        system_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence pin8_rise_s;
      $rose(pin8_in) && pin8_capture_cfg && !pin8_falling_edge && !pin8_lock_en;
   endsequence
   // an unsynchronised pin would strobe too early
   sequence sync_wait_s;
      !pin8_capture_strobe [*2] ##[1:4] pin8_capture_strobe;
   endsequence
   rdata_idle_a: assert property (!(reg_rd && reg_addr == 12'h198) |=> reg_rdata == 32'h0)
      else $error("read data without a read");
   reserved_zero_a: assert property (reg_rdata[31:25] == 7'h00 && reg_rdata[15:9] == 7'h00)
      else $error("reserved bits not zero");
   irq_gate_a: assert property (system_irq == (time_protocol_summary_flag
      && $past(time_protocol_summary_enable))) else $error("irq not summary and enable");
   pin8_sync_a: assert property (pin8_rise_s |-> sync_wait_s)
      else $error("pin strobe timing wrong");
   strobe_pulse_a: assert property (pin8_capture_strobe |=> !pin8_capture_strobe [*3])
      else $error("pin event counted twice");
   strobe_cfg_a: assert property (pin8_capture_strobe |-> pin8_capture_cfg)
      else $error("strobe without configured event");
   flag_out_a: assert property (clock_value >= {target_upper_word, target_lower_word}
      && pin8_event_mode == 2'h2 |=> pin8_flag_out) else $error("target flag not on pin");
   mode_gate_a: assert property (pin8_flag_out |-> $past(pin8_event_mode) == 2'h2)
      else $error("flag on pin in wrong mode");
endmodule
bind ptpise_top ptpise_top_sva i_ptpise_top_sva (.*);
`default_nettype wire

//--- verification/ptpise_top_tb_top.sv
/* ptpise_top_tb_top: register-level tests of the event flags.
   Assumes the pin source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module ptpise_top_tb_top;
   logic        clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, gen = 0, lock = 0, tclr = 0;
   logic        cfg8 = 1;
   logic [11:0] reg_addr = 12'h198;
   logic [31:0] reg_wdata = '0, rdata;
   logic [63:0] tgt = 64'h1_0000_0000, clk_val = '0;
   logic [5:0]  cap = '0;
   logic [1:0]  go = '0, pin, pstb, fout, mode = 2'h2;
   logic        sum, irq;
   int          n_fail = 0, cmp_count = 0, cyc = 0, stb8 = 0, stb9 = 0, s8;
   ptpise_top i_ptpise_top (.clk_sys, .arst_n, .clk_en(1'h1), .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata(rdata), .port2_rx_capture(cap[5]), .port2_tx_capture(cap[4]),
      .port1_rx_capture(cap[3]), .port1_tx_capture(cap[2]), .port0_rx_capture(cap[1]),
      .port0_tx_capture(cap[0]), .pin9_in(pin[1]), .pin8_in(pin[0]), .pin9_capture_cfg(1'h1),
      .pin8_capture_cfg(cfg8), .pin9_falling_edge(1'h0), .pin8_falling_edge(1'h0),
      .pin9_timer_clear_en(tclr), .pin8_timer_clear_en(tclr), .pin8_lock_en(lock),
      .pin9_event_mode(mode), .pin8_event_mode(mode), .clock_value(clk_val),
      .target_upper_word(tgt[63:32]), .target_lower_word(tgt[31:0]),
      .time_protocol_summary_enable(gen), .time_protocol_summary_flag(sum), .system_irq(irq),
      .pin9_capture_strobe(pstb[1]), .pin8_capture_strobe(pstb[0]),
      .pin9_flag_out(fout[1]), .pin8_flag_out(fout[0]));
   ptpise_pin_src i_ptpise_pin_src (.clk_sys, .go, .pin);
   always #5 clk_sys = ~clk_sys;
   task automatic end_sim;
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (pstb[0]) stb8++;
      if (pstb[1]) stb9++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [31:0] d);
      reg_wr = 1; reg_wdata = d; tick(1); reg_wr = 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      reg_rd = 1; reg_addr = a; tick(1); reg_rd = 0; reg_addr = 12'h198; chk(rdata, exp);
   endtask
   task automatic pin_ev(input logic [1:0] p);
      go = p; tick(1); go = 2'h0; tick(8);
   endtask
   initial begin
      tick(2); arst_n = 1;
      rd(12'h198, 32'h0);
      wr(32'hFFFF_FFFF);
      rd(12'h198, 32'h01FF_0000);
      rd(12'h19C, 32'h0);
      gen = 1;
      for (int i = 0; i < 6; i++) begin
         cap = 6'h01 << i; tick(1); cap = 6'h00; tick(1);
         chk({sum, irq}, 32'h3);
         wr(32'h01FF_0000);
         rd(12'h198, 32'h01FF_0000 | (32'h8 << i));
         wr(32'h01FF_0000 | (32'h8 << i));
         rd(12'h198, 32'h01FF_0000);
         chk(sum, 32'h0);
      end
      gen = 0; wr(32'h0);
      cap = 6'h20; tick(1); cap = 6'h00; tick(1);
      chk(sum, 32'h0);
      rd(12'h198, 32'h100);
      wr(32'h0100_0000); tick(1);
      chk({sum, irq}, 32'h2);
      gen = 1; tick(1);
      chk(irq, 32'h1);
      cap = 6'h20; wr(32'h0100_0100); cap = 6'h00;
      rd(12'h198, 32'h0100_0100);
      wr(32'h100);
      pin_ev(2'h1); rd(12'h198, 32'h2);
      chk(stb8, 32'h1);
      pin_ev(2'h2); rd(12'h198, 32'h6);
      chk(stb9, 32'h1);
      lock = 1; s8 = stb8;
      pin_ev(2'h1); rd(12'h198, 32'h6);
      chk(stb8, s8);
      wr(32'h6); clk_val = tgt; tick(2);
      chk(fout, 32'h3);
      clk_val = '0; rd(12'h198, 32'h1);
      wr(32'h1); rd(12'h198, 32'h0);
      clk_val = tgt + 64'h1; tick(1); clk_val = '0;
      tclr = 1; lock = 0;
      pin_ev(2'h2); rd(12'h198, 32'h4);
      cfg8 = 0; s8 = stb8;
      pin_ev(2'h1); rd(12'h198, 32'h4);
      chk(stb8, s8);
      end_sim;
   end
endmodule
`default_nettype wire

//--- verilog/ptpise_pin_sync.sv
/*
 * ptpise_pin_sync: three-stage synchroniser with edge detection for pin inputs.
 * Assumes asynchronous pins; a change counts while stages two and three differ.
 */
`timescale 1ns/1ps
`default_nettype none
module ptpise_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   // pins
   input  wire logic [WIDTH-1:0] pin_async,
   // synchronised
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   // s1 feeds only s2; edges use stages two and three
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else if (clk_en) begin
         s1_reg <= pin_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign rise = s2_reg & ~s3_reg;
   assign fall = ~s2_reg & s3_reg;
endmodule
`default_nettype wire

//--- verilog/ptpise_pkg.sv
/*
 * ptpise_pkg: constants for the time-protocol event status and enable block.
 * Assumes a 32-bit register port at the documented offset, system clock 100 MHz.
 */
// Notes on behaviour
// - writing one to a flag position clears that flag, writing zero leaves it.
// - the OR of all enabled flags drives summary bit 29 of the global interrupt status.
// - flags set from their sources regardless of enables, which only gate the summary.
// - the system interrupt asserts only when the summary and global enable bit 29 are both set.
// - enables sit at 24:16 paired with flags 8:0, reset to zero, other bits read zero.
// - flag 8 sets on a port 2 receive capture and flag 7 on a port 2 transmit capture.
// - flag 6 sets on a port 1 receive capture and flag 5 on a port 1 transmit capture.
// - flag 4 sets on a fabric-to-external-port capture, counted as port 0 receive.
// - flag 3 sets on an external-port-to-fabric capture, counted as port 0 transmit.
// - flag 2 sets on a configured pin 9 capture event and flag 1 on pin 8.
// - pin capture inputs are edge triggered and the source holds each level over 40 ns.
// - flag 0 sets when the 64-bit clock reaches or passes the 64-bit target.
// - an enabled active edge on pin 9 or 8 also clears the target-match flag.
// - with pin 8 lock on and flag 1 set, a new pin 8 capture does not overwrite the clock.
// - a pin event mode of 10 drives the current target-match flag onto that pin.
package ptpise_pkg;
   localparam logic [11:0] PTPISE_STS_EN_OFS   = 12'h198;
   localparam int          PTPISE_NUM_FLAGS    = 9;
   localparam int          PTPISE_FLAG_LSB     = 0;
   localparam int          PTPISE_EN_LSB       = 16;
   localparam int          PTPISE_SUMMARY_BIT  = 29;
   localparam logic [8:0]  PTPISE_FLAG_RST     = 9'h000;
   localparam logic [8:0]  PTPISE_EN_RST       = 9'h000;
   localparam logic [1:0]  PTPISE_MODE_FLAG    = 2'h2;
   localparam int          PTPISE_FLAG_P2RX    = 8;
   localparam int          PTPISE_FLAG_P2TX    = 7;
   localparam int          PTPISE_FLAG_P1RX    = 6;
   localparam int          PTPISE_FLAG_P1TX    = 5;
   localparam int          PTPISE_FLAG_P0RX    = 4;
   localparam int          PTPISE_FLAG_P0TX    = 3;
   localparam int          PTPISE_FLAG_PIN9    = 2;
   localparam int          PTPISE_FLAG_PIN8    = 1;
   localparam int          PTPISE_FLAG_TIMER   = 0;
   localparam int          PTPISE_CLK_NS       = 10;
   localparam int          PTPISE_PIN_HOLD_NS  = 40;
   // least hold, rounded up to whole cycles
   localparam int          PTPISE_PIN_HOLD_CYC =
      (PTPISE_PIN_HOLD_NS + PTPISE_CLK_NS - 1) / PTPISE_CLK_NS;
endpackage

//--- verilog/ptpise_top.sv
/*
 * ptpise_top: event flags, enables and summary for the time-protocol unit.
 * Assumes capture strobes from packet-match logic on clk_sys, pins asynchronous,
 * and a simple single-cycle register port.
 */
`timescale 1ns/1ps
`default_nettype none
module ptpise_top
   import ptpise_pkg::*;
#(
   parameter int FLAGS = ptpise_pkg::PTPISE_NUM_FLAGS
) (
   // clock, reset, enable
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   // register port
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   // packet-match capture strobes, one cycle each
   input  wire logic        port2_rx_capture,
   input  wire logic        port2_tx_capture,
   input  wire logic        port1_rx_capture,
   input  wire logic        port1_tx_capture,
   input  wire logic        port0_rx_capture,
   input  wire logic        port0_tx_capture,
   // capture pins, asynchronous
   input  wire logic        pin9_in,
   input  wire logic        pin8_in,
   // pin configuration
   input  wire logic        pin9_capture_cfg,
   input  wire logic        pin8_capture_cfg,
   input  wire logic        pin9_falling_edge,
   input  wire logic        pin8_falling_edge,
   input  wire logic        pin9_timer_clear_en,
   input  wire logic        pin8_timer_clear_en,
   input  wire logic        pin8_lock_en,
   input  wire logic [1:0]  pin9_event_mode,
   input  wire logic [1:0]  pin8_event_mode,
   // protocol clock and target
   input  wire logic [63:0] clock_value,
   input  wire logic [31:0] target_upper_word,
   input  wire logic [31:0] target_lower_word,
   // global enable bit 29 of the interrupt enable
   input  wire logic        time_protocol_summary_enable,
   // outputs
   output logic             time_protocol_summary_flag,
   output logic             system_irq,
   output logic             pin9_capture_strobe,
   output logic             pin8_capture_strobe,
   output logic             pin9_flag_out,
   output logic             pin8_flag_out
);
   import ptpise_pkg::*;

   logic [FLAGS-1:0] flag_reg;
   logic [FLAGS-1:0] flag_next;
   logic [FLAGS-1:0] enable_reg;
   logic [FLAGS-1:0] set_vec;
   logic [FLAGS-1:0] clr_vec;
   logic [1:0]       pin_rise;
   logic [1:0]       pin_fall;
   logic             pin9_edge;
   logic             pin8_edge;
   logic             target_hit;
   logic             wr_hit;
   logic             rd_hit;

   // pin 9 in bit 1, pin 8 in bit 0
   ptpise_pin_sync #(
      .WIDTH     (2)
   ) u_sync (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .pin_async ({pin9_in, pin8_in}),
      .rise      (pin_rise),
      .fall      (pin_fall)
   );

   // edge polarity chosen by configuration; level shorter than hold may be missed
   assign pin9_edge = pin9_falling_edge ? pin_fall[1] : pin_rise[1];
   assign pin8_edge = pin8_falling_edge ? pin_fall[0] : pin_rise[0];

   assign target_hit = clock_value >= {target_upper_word, target_lower_word};
   assign wr_hit     = reg_wr && (reg_addr == PTPISE_STS_EN_OFS);
   assign rd_hit     = reg_rd && (reg_addr == PTPISE_STS_EN_OFS);

   // sources set flags irrespective of enables
   always_comb begin
      set_vec = '0;
      set_vec[PTPISE_FLAG_P2RX]  = port2_rx_capture;
      set_vec[PTPISE_FLAG_P2TX]  = port2_tx_capture;
      set_vec[PTPISE_FLAG_P1RX]  = port1_rx_capture;
      set_vec[PTPISE_FLAG_P1TX]  = port1_tx_capture;
      set_vec[PTPISE_FLAG_P0RX]  = port0_rx_capture;
      set_vec[PTPISE_FLAG_P0TX]  = port0_tx_capture;
      set_vec[PTPISE_FLAG_PIN9]  = pin9_capture_cfg && pin9_edge;
      set_vec[PTPISE_FLAG_PIN8]  = pin8_capture_cfg && pin8_edge;
      set_vec[PTPISE_FLAG_TIMER] = target_hit;
   end

   always_comb begin
      clr_vec = '0;
      if (wr_hit) begin
         clr_vec = reg_wdata[PTPISE_FLAG_LSB +: FLAGS];
      end
      // pin edge also acknowledges the target match
      if ((pin9_timer_clear_en && pin9_edge) || (pin8_timer_clear_en && pin8_edge)) begin
         clr_vec[PTPISE_FLAG_TIMER] = 1'b1;
      end
   end

   // set wins over clear so no event is lost
   assign flag_next = (flag_reg & ~clr_vec) | set_vec;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= PTPISE_FLAG_RST;
      end else if (clk_en) begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         enable_reg <= PTPISE_EN_RST;
      end else if (clk_en && wr_hit) begin
         enable_reg <= reg_wdata[PTPISE_EN_LSB +: FLAGS];
      end
   end

   // read data registered; reserved bits read zero
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         if (rd_hit) begin
            reg_rdata <= '0;
            reg_rdata[PTPISE_EN_LSB +: FLAGS]   <= enable_reg;
            reg_rdata[PTPISE_FLAG_LSB +: FLAGS] <= flag_reg;
         end else begin
            reg_rdata <= '0;
         end
      end
   end

   // summary and interrupt follow the registered flags by one cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         time_protocol_summary_flag <= 1'b0;
         system_irq                 <= 1'b0;
      end else if (clk_en) begin
         time_protocol_summary_flag <= |(flag_reg & enable_reg);
         system_irq <= (|(flag_reg & enable_reg)) && time_protocol_summary_enable;
      end
   end

   // capture strobes to the clock-capture registers; lock holds the first pin 8 value
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin9_capture_strobe <= 1'b0;
         pin8_capture_strobe <= 1'b0;
      end else if (clk_en) begin
         pin9_capture_strobe <= set_vec[PTPISE_FLAG_PIN9];
         pin8_capture_strobe <= set_vec[PTPISE_FLAG_PIN8]
                                && !(pin8_lock_en && flag_reg[PTPISE_FLAG_PIN8]);
      end
   end

   // level mode: pin shows the target-match flag
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin9_flag_out <= 1'b0;
         pin8_flag_out <= 1'b0;
      end else if (clk_en) begin
         pin9_flag_out <= (pin9_event_mode == PTPISE_MODE_FLAG)
                          && flag_next[PTPISE_FLAG_TIMER];
         pin8_flag_out <= (pin8_event_mode == PTPISE_MODE_FLAG)
                          && flag_next[PTPISE_FLAG_TIMER];
      end
   end
endmodule
`default_nettype wire
